// *** verilog/mas_pkg.sv ***
// Shared constants, types and helpers for the instruction execution block
package mas_pkg;

  // ***************
  // Register map
  // ***************
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_ACC   = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_VIEW  = 8'h0C;
  localparam logic [7:0] REG_PC    = 8'h10;
  localparam logic [7:0] REG_STACK = 8'h14;
  localparam logic [7:0] REG_WDT   = 8'h18;

  // ***************
  // Field layout
  // ***************
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_LIT_LSB  = 16;
  localparam int CMD_BIT_LSB  = 24;
  localparam int FLG_WDT_LSB  = 4;
  localparam int STK_SP_LSB   = 16;

  // ***************
  // Sizes and reset values
  // ***************
  localparam int MEM_DEPTH   = 160;
  localparam int PC_W        = 12;
  localparam int STACK_DEPTH = 6;
  localparam int WDT_W       = 16;
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  localparam logic [2:0] SP_LAST  = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] BCD_MAX  = 4'h9;
  localparam logic [3:0] BCD_ADJ  = 4'h6;

  // ***************
  // Types
  // ***************
  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_ADC  = 5'h01, OP_ADD_CARRY_INTO_MEMORY = 5'h02, OP_ADD  = 5'h03,
    OP_ADDI = 5'h04, OP_SUM_INTO_MEMORY = 5'h05, OP_AND  = 5'h06, OP_ANDI = 5'h07,
    OP_MASK_INTO_MEMORY = 5'h08, OP_CLR  = 5'h09, OP_CLRB = 5'h0A, OP_WCLR = 5'h0B,
    OP_WPR1 = 5'h0C, OP_WPR2 = 5'h0D, OP_CPL  = 5'h0E, OP_INVERT_INTO_WORK = 5'h0F,
    OP_DAA  = 5'h10, OP_DEC  = 5'h11, OP_CALL = 5'h12, OP_HALT = 5'h13,
    OP_PEEK = 5'h14, OP_POKE = 5'h15
  } mas_op_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC  = 3'b100
  } mas_state_type;

  typedef struct packed {
    logic signed_range_flag;
    logic zero;
    logic low_nibble_carry;
    logic carry;
  } mas_flags_type;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mas_mem_req_type;

  typedef struct packed {
    logic wdt_clear;
    logic first_preclear_op;
    logic second_preclear_op;
    logic halt;
  } mas_wdt_ops_type;

  typedef struct packed {
    logic       ov;
    logic       ac;
    logic       c;
    logic [7:0] res;
  } mas_sum_type;

  // Eight-bit add with carry-in, nibble carry and signed overflow
  function automatic mas_sum_type mas_add8(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
    logic [4:0]  lo;
    logic [8:0]  full;
    mas_sum_type s;
    lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    s.res = full[7:0];
    s.c   = full[8];
    s.ac  = lo[4];
    s.ov  = (a[7] == b[7]) && (full[7] != a[7]);
    return s;
  endfunction : mas_add8

  // BCD adjust: returns {carry, result}
  function automatic logic [8:0] mas_bcd(input logic [7:0] a, input logic ac,
                                         input logic c);
    logic [4:0] lo;
    logic [4:0] hs;
    logic [3:0] hi;
    logic       cout;
    lo   = {1'b0, a[3:0]};
    cout = c;
    if (a[3:0] > BCD_MAX || ac) begin
      lo = {1'b0, a[3:0]} + {1'b0, BCD_ADJ};
    end
    // High nibble test must include the low nibble's carry, or 9 plus carry slips through
    hs = {1'b0, a[7:4]} + {4'h0, lo[4]};
    hi = hs[3:0];
    if (hs > {1'b0, BCD_MAX} || c) begin
      hi   = a[7:4] + BCD_ADJ + {3'h0, lo[4]};
      cout = 1'b1;
    end
    return {cout, hi, lo[3:0]};
  endfunction : mas_bcd

endpackage : mas_pkg

// *** verilog/mas_data_mem.sv ***
// Data memory with registered read port
`timescale 1ns/100ps
`default_nettype none
module mas_data_mem (
  // System
  input  wire logic                     clock,
  input  wire logic                     clock_en,
  // Access
  input  wire mas_pkg::mas_mem_req_type req,
  output logic [7:0]                    rdata
);
  logic [7:0] mem [mas_pkg::MEM_DEPTH];

  // Addresses past the top read zero and drop writes
  always_ff @(posedge clock) begin
    if (clock_en) begin
      if (req.we && req.addr < 8'(mas_pkg::MEM_DEPTH)) begin
        mem[req.addr] <= req.wdata;
      end
      rdata <= (req.addr < 8'(mas_pkg::MEM_DEPTH)) ? mem[req.addr] : 8'h00;
    end
  end
endmodule : mas_data_mem
`default_nettype wire

// *** verilog/mas_watchdog.sv ***
// Watchdog counter with expiry and halt status flags
`timescale 1ns/100ps
`default_nettype none
module mas_watchdog (
  // System
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clock_en,
  // Operations
  input  wire mas_pkg::mas_wdt_ops_type  ops,
  // Status
  output logic [mas_pkg::WDT_W-1:0]      watchdog_counter,
  output logic                           watchdog_expiry_flag,
  output logic                           halt_entered_flag
);
  logic [mas_pkg::WDT_W-1:0] next_count;
  logic next_expiry;
  logic next_halt;
  logic pend1;
  logic pend2;
  logic next_pend1;
  logic next_pend2;
  logic do_clear;

  always_comb begin
    // A pre-clear only counts once its partner has also arrived
    do_clear   = ops.wdt_clear || (ops.first_preclear_op && pend2) ||
                 (ops.second_preclear_op && pend1);
    next_pend1 = (pend1 || ops.first_preclear_op) && !do_clear;
    next_pend2 = (pend2 || ops.second_preclear_op) && !do_clear;
    next_count = do_clear ? '0 : watchdog_counter + 1'b1;
    // Expiry set beats a same-cycle clear
    next_expiry = (&watchdog_counter) || (watchdog_expiry_flag && !do_clear && !ops.halt);
    next_halt   = ops.halt || (halt_entered_flag && !do_clear);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter     <= '0;
      watchdog_expiry_flag <= 1'b0;
      halt_entered_flag    <= 1'b0;
      pend1                <= 1'b0;
      pend2                <= 1'b0;
    end else if (clock_en) begin
      watchdog_counter     <= next_count;
      watchdog_expiry_flag <= next_expiry;
      halt_entered_flag    <= next_halt;
      pend1                <= next_pend1;
      pend2                <= next_pend2;
    end
  end

  // ***************
  // Checks
  // ***************
  AST_WDT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n || !clock_en)
    ops.wdt_clear && !(&watchdog_counter) |=> watchdog_counter == '0 &&
    !watchdog_expiry_flag && !halt_entered_flag) else $error("watchdog clear failed");
  AST_PRE_REPEAT: assert property (@(posedge clock) disable iff (!rst_n || !clock_en)
    ops.first_preclear_op && !pend2 && !ops.second_preclear_op && watchdog_counter != '0
    |=> watchdog_counter == mas_pkg::WDT_W'($past(watchdog_counter) + 1'b1))
    else $error("lone pre-clear cleared the watchdog");
  CVR_PAIR: cover property (@(posedge clock) disable iff (!rst_n)
    ops.second_preclear_op && pend1);
endmodule : mas_watchdog
`default_nettype wire

// *** verilog/mas_core.sv ***
// Instruction execution core with AXI4-Lite register access
`timescale 1ns/100ps
`default_nettype none
module mas_core (
  // System
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clock_en,
  // AXI4-Lite write
  input  wire logic        awvalid,
  input  wire logic [7:0]  awaddr,
  output logic             awready,
  input  wire logic        wvalid,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             wready,
  output logic             bvalid,
  output logic [1:0]       bresp,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic        arvalid,
  input  wire logic [7:0]  araddr,
  output logic             arready,
  output logic             rvalid,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        rready,
  // Status
  output logic             watchdog_expiry_flag
);
  // ***************
  // Reset release
  // ***************
  logic rst_q1;
  logic rst_n_s;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1  <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_q1  <= 1'b1;
      rst_n_s <= rst_q1;
    end
  end

  // ***************
  // Declarations
  // ***************
  mas_pkg::mas_state_type    state, next_state;
  logic [31:0]               cmd, next_cmd;
  logic [7:0]                acc, next_acc;
  logic [7:0]                view, next_view;
  mas_pkg::mas_flags_type    flags, next_flags;
  logic [mas_pkg::PC_W-1:0]  pc, next_pc;
  logic [mas_pkg::PC_W-1:0]  stack [mas_pkg::STACK_DEPTH];
  logic [mas_pkg::PC_W-1:0]  next_stack [mas_pkg::STACK_DEPTH];
  logic [2:0]                sp, next_sp;
  mas_pkg::mas_mem_req_type  mem_req;
  mas_pkg::mas_wdt_ops_type  wdt_ops;
  logic [7:0]                mem_rdata;
  logic [mas_pkg::WDT_W-1:0] wdt_count;
  logic                      halt_flag;
  mas_pkg::mas_op_type       op;
  logic [7:0]                lit;
  mas_pkg::mas_sum_type      sum;
  logic [8:0]                bcd;
  logic [7:0]                res;
  logic                      aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0]                aw_addr, next_aw_addr;
  logic [31:0]               w_data, next_w_data;
  logic [3:0]                w_strb, next_w_strb;
  logic                      next_awready, next_wready, next_bvalid, next_arready;
  logic                      next_rvalid;
  logic [1:0]                next_bresp, next_rresp;
  logic [31:0]               next_rdata;
  logic                      do_write, busy, wr_ok;

  // Full map for reads; writes also exclude REG_VIEW, REG_STACK and REG_WDT
  function automatic logic reg_known(input logic [7:0] a);
    if (a == mas_pkg::REG_CMD || a == mas_pkg::REG_ACC || a == mas_pkg::REG_FLAGS) begin
      return 1'b1;
    end else if (a == mas_pkg::REG_VIEW || a == mas_pkg::REG_PC) begin
      return 1'b1;
    end else if (a == mas_pkg::REG_STACK || a == mas_pkg::REG_WDT) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : reg_known

  // ***************
  // Submodules
  // ***************
  mas_data_mem u_mem (
    .clock    (clock),
    .clock_en (clock_en),
    .req      (mem_req),
    .rdata    (mem_rdata)
  );

  mas_watchdog u_wdt (
    .clock                (clock),
    .rst_n                (rst_n_s),
    .clock_en             (clock_en),
    .ops                  (wdt_ops),
    .watchdog_counter     (wdt_count),
    .watchdog_expiry_flag (watchdog_expiry_flag),
    .halt_entered_flag    (halt_flag)
  );

  // ***************
  // Register bus
  // ***************
  assign busy     = state != mas_pkg::ST_IDLE;
  assign do_write = aw_got && w_got && !bvalid;
  // Software may not touch core state while an instruction is in flight
  assign wr_ok    = reg_known(aw_addr) && !busy && aw_addr != mas_pkg::REG_VIEW &&
                    aw_addr != mas_pkg::REG_STACK && aw_addr != mas_pkg::REG_WDT;

  always_comb begin
    next_aw_got  = aw_got || (awvalid && awready);
    next_aw_addr = (awvalid && awready) ? awaddr : aw_addr;
    next_w_got   = w_got || (wvalid && wready);
    next_w_data  = (wvalid && wready) ? wdata : w_data;
    next_w_strb  = (wvalid && wready) ? wstrb : w_strb;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wr_ok ? mas_pkg::RESP_OKAY : mas_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready  = !next_w_got && !next_bvalid;
    next_rvalid  = rvalid && !rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = reg_known(araddr) ? mas_pkg::RESP_OKAY : mas_pkg::RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      if (araddr == mas_pkg::REG_CMD) begin
        next_rdata = {cmd[31:1], busy};
      end else if (araddr == mas_pkg::REG_ACC) begin
        next_rdata = {24'h00_0000, acc};
      end else if (araddr == mas_pkg::REG_FLAGS) begin
        next_rdata = {26'h000_0000, halt_flag, watchdog_expiry_flag, flags};
      end else if (araddr == mas_pkg::REG_VIEW) begin
        next_rdata = {24'h00_0000, view};
      end else if (araddr == mas_pkg::REG_PC) begin
        next_rdata = {20'h0_0000, pc};
      end else if (araddr == mas_pkg::REG_STACK) begin
        next_rdata = {13'h0000, sp, 4'h0, stack[sp]};
      end else if (araddr == mas_pkg::REG_WDT) begin
        next_rdata = {16'h0000, wdt_count};
      end
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      aw_got  <= 1'b0;
      aw_addr <= 8'h00;
      w_got   <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= mas_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= mas_pkg::RESP_OKAY;
    end else if (clock_en) begin
      aw_got  <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got   <= next_w_got;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // ***************
  // Execution
  // ***************
  assign op  = mas_pkg::mas_op_type'(cmd[mas_pkg::CMD_OP_LSB +: 5]);
  assign lit = cmd[mas_pkg::CMD_LIT_LSB +: 8];

  always_comb begin
    next_state = state;
    next_cmd   = cmd;
    next_acc   = acc;
    next_view  = view;
    next_flags = flags;
    next_pc    = pc;
    next_stack = stack;
    next_sp    = sp;
    wdt_ops    = '0;
    mem_req    = '{we: 1'b0, addr: cmd[mas_pkg::CMD_ADDR_LSB +: 8], wdata: 8'h00};
    // One adder for every add form; carry-in only for the carry forms
    sum = mas_pkg::mas_add8(acc, (op == mas_pkg::OP_ADDI) ? lit : mem_rdata,
                            (op == mas_pkg::OP_ADC || op == mas_pkg::OP_ADD_CARRY_INTO_MEMORY) && flags.carry);
    bcd = mas_pkg::mas_bcd(acc, flags.low_nibble_carry, flags.carry);
    res = 8'h00;
    case (state)
      mas_pkg::ST_IDLE: begin
        if (do_write && wr_ok) begin
          if (aw_addr == mas_pkg::REG_CMD && w_strb[0]) begin
            next_cmd   = w_data;
            next_state = mas_pkg::ST_FETCH;
          end else if (aw_addr == mas_pkg::REG_ACC && w_strb[0]) begin
            next_acc = w_data[7:0];
          end else if (aw_addr == mas_pkg::REG_FLAGS && w_strb[0]) begin
            next_flags = w_data[3:0];
          end else if (aw_addr == mas_pkg::REG_PC) begin
            next_pc = w_data[mas_pkg::PC_W-1:0];
          end
        end
      end
      mas_pkg::ST_FETCH: begin
        next_state = mas_pkg::ST_EXEC;
      end
      mas_pkg::ST_EXEC: begin
        next_state = mas_pkg::ST_IDLE;
        case (op)
          mas_pkg::OP_ADC, mas_pkg::OP_ADD, mas_pkg::OP_ADDI,
          mas_pkg::OP_ADD_CARRY_INTO_MEMORY, mas_pkg::OP_SUM_INTO_MEMORY: begin
            next_flags = '{sum.ov, ~|sum.res, sum.ac, sum.c};
            if (op == mas_pkg::OP_ADD_CARRY_INTO_MEMORY || op == mas_pkg::OP_SUM_INTO_MEMORY) begin
              mem_req.we    = 1'b1;
              mem_req.wdata = sum.res;
            end else begin
              next_acc = sum.res;
            end
          end
          mas_pkg::OP_AND, mas_pkg::OP_ANDI: begin
            res = acc & ((op == mas_pkg::OP_ANDI) ? lit : mem_rdata);
            next_acc        = res;
            next_flags.zero = ~|res;
          end
          mas_pkg::OP_MASK_INTO_MEMORY: begin
            res             = acc & mem_rdata;
            mem_req.we      = 1'b1;
            mem_req.wdata   = res;
            next_flags.zero = ~|res;
          end
          mas_pkg::OP_CLR: begin
            mem_req.we = 1'b1;
          end
          mas_pkg::OP_CLRB: begin
            mem_req.we    = 1'b1;
            mem_req.wdata = mem_rdata & ~(8'h01 << cmd[mas_pkg::CMD_BIT_LSB +: 3]);
          end
          mas_pkg::OP_WCLR: wdt_ops.wdt_clear = 1'b1;
          mas_pkg::OP_WPR1: wdt_ops.first_preclear_op = 1'b1;
          mas_pkg::OP_WPR2: wdt_ops.second_preclear_op = 1'b1;
          mas_pkg::OP_HALT: wdt_ops.halt = 1'b1;
          mas_pkg::OP_CPL, mas_pkg::OP_INVERT_INTO_WORK, mas_pkg::OP_DEC: begin
            res = (op == mas_pkg::OP_DEC) ? mem_rdata - 8'h01 : ~mem_rdata;
            next_flags.zero = ~|res;
            if (op == mas_pkg::OP_INVERT_INTO_WORK) begin
              next_acc = res;
            end else begin
              mem_req.we    = 1'b1;
              mem_req.wdata = res;
            end
          end
          mas_pkg::OP_DAA: begin
            mem_req.we       = 1'b1;
            mem_req.wdata    = bcd[7:0];
            next_flags.carry = bcd[8];
          end
          mas_pkg::OP_CALL: begin
            // Six-deep stack wraps and overwrites the oldest entry
            next_stack[sp] = pc + 1'b1;
            next_sp        = (sp == mas_pkg::SP_LAST) ? 3'h0 : sp + 3'h1;
            next_pc        = cmd[mas_pkg::CMD_LIT_LSB +: mas_pkg::PC_W];
          end
          mas_pkg::OP_PEEK: next_view = mem_rdata;
          mas_pkg::OP_POKE: begin
            mem_req.we    = 1'b1;
            mem_req.wdata = lit;
          end
          default: ;
        endcase
      end
      default: next_state = mas_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state <= mas_pkg::ST_IDLE;
      cmd   <= 32'h0000_0000;
      acc   <= mas_pkg::ACC_RST;
      view  <= 8'h00;
      flags <= '0;
      pc    <= mas_pkg::PC_RST;
      sp    <= 3'h0;
      for (int i = 0; i < mas_pkg::STACK_DEPTH; i++) begin
        stack[i] <= mas_pkg::PC_RST;
      end
    end else if (clock_en) begin
      state <= next_state;
      cmd   <= next_cmd;
      acc   <= next_acc;
      view  <= next_view;
      flags <= next_flags;
      pc    <= next_pc;
      sp    <= next_sp;
      stack <= next_stack;
    end
  end

  // ***************
  // Checks
  // ***************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n_s || !clock_en);
  logic ex;
  assign ex = state == mas_pkg::ST_EXEC;

  AST_ADC_SUM: assert property (ex && op == mas_pkg::OP_ADC |=>
    {flags.carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(mem_rdata)} + 9'($past(flags.carry)))
    else $error("add with carry wrong");
  AST_SUM_INTO_MEMORY_MEM: assert property (ex && op == mas_pkg::OP_SUM_INTO_MEMORY |-> mem_req.we &&
    mem_req.wdata == 8'(acc + mem_rdata)) else $error("memory add wrong");
  AST_ADDI_OV: assert property (ex && op == mas_pkg::OP_ADDI && acc == 8'h7F && lit == 8'h01
    |=> acc == 8'h80 && flags.signed_range_flag && !flags.carry) else $error("overflow wrong");
  AST_AND_FLAGS: assert property (ex && op == mas_pkg::OP_AND |=> acc == $past(acc & mem_rdata)
    && flags.carry == $past(flags.carry) && flags.signed_range_flag == $past(flags.signed_range_flag))
    else $error("logic op disturbed flags");
  AST_CLR_MEM: assert property (ex && op == mas_pkg::OP_CLR |-> mem_req.we &&
    mem_req.wdata == 8'h00 ##1 flags == $past(flags)) else $error("clear wrong");
  AST_INVERT_INTO_WORK_ACC: assert property (ex && op == mas_pkg::OP_INVERT_INTO_WORK |-> !mem_req.we
    ##1 acc == ~$past(mem_rdata)) else $error("invert into work wrong");
  AST_DEC_MEM: assert property (ex && op == mas_pkg::OP_DEC |->
    mem_req.wdata == 8'(mem_rdata - 8'h01) ##1 flags.zero == ($past(mem_rdata) == 8'h01))
    else $error("decrement wrong");
  AST_CALL_PC: assert property (ex && op == mas_pkg::OP_CALL |=>
    pc == $past(cmd[27:16]) && stack[$past(sp)] == 12'($past(pc) + 1'b1)) else $error("call wrong");
  AST_FETCH_EXEC: assert property (state == mas_pkg::ST_FETCH |=> ex ##1 !busy)
    else $error("instruction sequence wrong");
  CVR_ADC: cover property (ex && op == mas_pkg::OP_ADC && flags.carry);
  CVR_DAA: cover property (ex && op == mas_pkg::OP_DAA);
  CVR_CALL: cover property (ex && op == mas_pkg::OP_CALL);
endmodule : mas_core
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the instruction execution core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clock = 1'h0, reset_n = 1'h0, clock_en = 1'h1, watchdog_expiry_flag;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  int miscompares = 0, n_checks = 0;
  mas_core uut (
    .clock   (clock),   .reset_n (reset_n), .clock_en (clock_en),
    .awvalid (awvalid), .awaddr  (awaddr),  .awready  (awready),
    .wvalid  (wvalid),  .wdata   (wdata),   .wstrb    (wstrb),   .wready (wready),
    .bvalid  (bvalid),  .bresp   (bresp),   .bready   (bready),
    .arvalid (arvalid), .araddr  (araddr),  .arready  (arready),
    .rvalid  (rvalid),  .rdata   (rdata),   .rresp    (rresp),   .rready (rready),
    .watchdog_expiry_flag (watchdog_expiry_flag)
  );
  // ***************
  // Bus and check tasks
  // ***************
  task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s exp %h got %h", s, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta = 1'h0, tw = 1'h0;
    @(posedge clock);
    {awvalid, wvalid, bready} <= 3'h7;
    awaddr <= a;
    wdata <= v;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      ta |= awready;
      tw |= wready;
    end while (!(ta && tw));
    do @(posedge clock); while (bvalid !== 1'h1);
    bready <= 1'h0;
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    {arvalid, rready} <= 2'h3;
    araddr <= a;
    do @(posedge clock); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clock); while (rvalid !== 1'h1);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask : rd
  // Fixed byte address keeps every case on one memory cell
  task automatic ex(input mas_pkg::mas_op_type o, input logic [11:0] l);
    wr(mas_pkg::REG_CMD, {4'h0, l, 8'h21, 3'h0, o});
    do rd(mas_pkg::REG_CMD); while (d[0] !== 1'h0);
  endtask : ex
  // Packed as {acc, flags, mem} going in and coming out
  task automatic alu(input mas_pkg::mas_op_type o, input logic [19:0] i,
                     input logic [11:0] l, input logic [19:0] e);
    wr(mas_pkg::REG_ACC, {24'h0, i[19:12]});
    wr(mas_pkg::REG_FLAGS, {28'h0, i[11:8]});
    ex(mas_pkg::OP_POKE, {4'h0, i[7:0]});
    ex(o, l);
    rd(mas_pkg::REG_ACC);
    chk("acc", {4'h0, e[19:12]}, {4'h0, d[7:0]});
    rd(mas_pkg::REG_FLAGS);
    chk("flags", {8'h0, e[11:8]}, {8'h0, d[3:0]});
    ex(mas_pkg::OP_PEEK, 12'h0);
    rd(mas_pkg::REG_VIEW);
    chk("mem", {4'h0, e[7:0]}, {4'h0, d[7:0]});
  endtask : alu
  // ***************
  // Scenarios
  // ***************
  task automatic t_arith;
    alu(mas_pkg::OP_ADD, 20'h7F001, 12'h0, 20'h80A01);
    alu(mas_pkg::OP_ADC, 20'hFF100, 12'h0, 20'h00700);
    alu(mas_pkg::OP_ADD_CARRY_INTO_MEMORY, 20'h0F100, 12'h0, 20'h0F210);
    alu(mas_pkg::OP_ADDI, 20'h01033, 12'hFF, 20'h00733);
    alu(mas_pkg::OP_ADDI, 20'h7F000, 12'h001, 20'h80A00);
    alu(mas_pkg::OP_SUM_INTO_MEMORY, 20'h80080, 12'h0, 20'h80D00);
  endtask : t_arith
  task automatic t_logic;
    alu(mas_pkg::OP_AND, 20'h3CF0F, 12'h0, 20'h0CB0F);
    alu(mas_pkg::OP_ANDI, 20'hF0B55, 12'hF, 20'h00F55);
    alu(mas_pkg::OP_MASK_INTO_MEMORY, 20'hF000F, 12'h0, 20'hF0400);
    alu(mas_pkg::OP_CLR, 20'h115AA, 12'h0, 20'h11500);
    alu(mas_pkg::OP_CLRB, 20'h11AFF, 12'h700, 20'h11A7F);
    alu(mas_pkg::OP_INVERT_INTO_WORK, 20'h0045A, 12'h0, 20'hA505A);
    alu(mas_pkg::OP_CPL, 20'h12BFF, 12'h0, 20'h12F00);
  endtask : t_logic
  task automatic t_misc;
    alu(mas_pkg::OP_DAA, 20'hA5400, 12'h0, 20'hA5505);
    alu(mas_pkg::OP_DAA, 20'h4B000, 12'h0, 20'h4B051);
    alu(mas_pkg::OP_DAA, 20'h9A000, 12'h0, 20'h9A100);
    alu(mas_pkg::OP_DEC, 20'h00F00, 12'h0, 20'h00BFF);
    wr(mas_pkg::REG_PC, 32'h123);
    // Six pushes wrap the pointer back onto the first entry
    repeat (6) ex(mas_pkg::OP_CALL, 12'h456);
    rd(mas_pkg::REG_PC);
    chk("pc", 12'h456, d[11:0]);
    rd(mas_pkg::REG_STACK);
    chk("stack", 12'h124, d[11:0]);
    chk("sp", 12'h0, {9'h0, d[18:16]});
    rd(8'h40);
    chk("rresp", {10'h0, mas_pkg::RESP_SLVERR}, {10'h0, r});
  endtask : t_misc
  // Halt then clear, while the counter is still far from reaching all ones
  task automatic t_wdt;
    ex(mas_pkg::OP_HALT, 12'h0);
    ex(mas_pkg::OP_WCLR, 12'h0);
    rd(mas_pkg::REG_WDT);
    chk("wdt_hi", 12'h0, {4'h0, d[15:8]});
    rd(mas_pkg::REG_FLAGS);
    chk("wdt_flags", 12'h0, {10'h0, d[5:4]});
    chk("expiry_pin", 12'h0, {11'h0, watchdog_expiry_flag});
    // Same pre-clear twice must not clear; the other one then must
    ex(mas_pkg::OP_HALT, 12'h0);
    ex(mas_pkg::OP_WPR1, 12'h0);
    ex(mas_pkg::OP_WPR1, 12'h0);
    rd(mas_pkg::REG_FLAGS);
    chk("halt", 12'h1, {11'h0, d[5]});
    ex(mas_pkg::OP_WPR2, 12'h0);
    rd(mas_pkg::REG_FLAGS);
    chk("halt", 12'h0, {11'h0, d[5]});
  endtask : t_wdt
  task automatic close_out;
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (5) @(posedge clock);
    reset_n <= 1'h1;
    t_arith;
    t_logic;
    t_misc;
    t_wdt;
    close_out;
  end
  // Far beyond the run's length: 50000 cycles of the 5 ns clock
  initial begin
    #250000;
    miscompares++;
    close_out;
  end
endmodule : tb_top
`default_nettype wire
